/* src/audio_regs_pkg.sv */
// Register map, reset values and timing constants for the audio rate, gain and count register bank.
package audio_regs_pkg;
    // Printed offsets are register indexes; byte address is four times the index.
    localparam int ADDR_W = 8;
    localparam logic [5:0] IDX_PLAY_RATE = 6'h02;
    localparam logic [5:0] IDX_REC_RATE = 6'h03;
    localparam logic [5:0] IDX_VOICE_ATT = 6'h04;
    localparam logic [5:0] IDX_SYNTH_ATT = 6'h05;
    localparam logic [5:0] IDX_SER1_ATT = 6'h06;
    localparam logic [5:0] IDX_SER0_ATT = 6'h07;
    localparam logic [5:0] IDX_PLAY_BASE = 6'h08;
    localparam logic [5:0] IDX_PLAY_CUR = 6'h09;
    localparam logic [5:0] IDX_REC_BASE = 6'h0a;
    localparam logic [5:0] IDX_REC_CUR = 6'h0b;
    localparam logic [5:0] IDX_TICK_BASE = 6'h0c;
    localparam logic [5:0] IDX_TICK_CUR = 6'h0d;
    localparam logic [5:0] IDX_CONTROL = 6'h10;
    localparam logic [5:0] IDX_EFF_REC_RATE = 6'h11;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h12;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h13;
    // Control register fields.
    localparam int CTL_PLAY_EN = 0;
    localparam int CTL_REC_EN = 1;
    localparam int CTL_TICK_EN = 2;
    localparam int CTL_TICK_SEL = 3;
    localparam int CTL_INDEP_RATE = 4;
    // Interrupt status fields.
    localparam int IRQ_PLAY = 0;
    localparam int IRQ_REC = 1;
    localparam int IRQ_TICK = 2;
    // Attenuation register fields.
    localparam int ATT_LEFT_MUTE = 15;
    localparam int ATT_LEFT_LSB = 8;
    localparam int ATT_RIGHT_MUTE = 7;
    localparam int ATT_RIGHT_LSB = 0;
    localparam int ATT_W = 6;
    // Reset values.
    localparam logic [15:0] RATE_RESET = 16'h1f40;
    localparam logic [15:0] ATT_RESET = 16'h8080;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timebase: 10 us short period, 100 ms long period, at the system clock rate.
    localparam int CLK_HZ = 50000000;
    localparam int SHORT_PERIOD_US = 10;
    localparam int LONG_PERIOD_MS = 100;
    localparam int SHORT_PERIOD_CYCLES = CLK_HZ / 1000000 * SHORT_PERIOD_US;
    localparam int LONG_PERIOD_CYCLES = CLK_HZ / 1000 * LONG_PERIOD_MS;
endpackage

/* src/audio_rate_gain_count_regs.sv */
// AXI4-Lite register bank holding sample rates, source attenuation and DMA and timer counters.
//
// Behaviour
// - The playback rate is a 16-bit field in hertz, any value 4 kHz to 55.2 kHz with 1 Hz steps accepted.
// - The playback rate resets to 8000 Hz.
// - The capture rate is a 16-bit field in hertz with the same range and resolution.
// - With the independent capture rate bit clear, capture runs at the playback rate.
// - The capture rate resets to 8000 Hz.
// - Every source has 6-bit left and right attenuation, 1.5 dB per step from 0 dB.
// - Both serial input attenuation fields use that same scale.
// - Each 6-bit field spans 0 dB at code zero to 94.5 dB at full code.
// - Each mute bit passes its channel when 0 and silences it when 1, left and right independently.
// - A timer base write loads the timer current count, which decrements once per period while enabled.
// - The count after the timer reaches zero interrupts and reloads from the base.
// - The timer period is 10 us or 100 ms, chosen by the period select bit.
`timescale 1ns/10ps
module audio_rate_gain_count_regs
    import audio_regs_pkg::*;
#(
    parameter int LONG_CYCLES = LONG_PERIOD_CYCLES,
    parameter int SHORT_CYCLES = SHORT_PERIOD_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic play_dma_beat,
    input wire logic rec_dma_beat,
    output logic [15:0] play_rate_hz,
    output logic [15:0] rec_rate_hz,
    output logic [15:0] voice_atten,
    output logic [15:0] synth_atten,
    output logic [15:0] serial1_atten,
    output logic [15:0] serial0_atten,
    output logic play_channel_enable,
    output logic rec_channel_enable,
    output logic irq
);
    logic [15:0] prate_reg, prate_next, crate_reg, crate_next;
    logic [15:0] att_reg [4];
    logic [15:0] att_next [4];
    logic [15:0] pbase_reg, pbase_next, pcur_reg, pcur_next;
    logic [15:0] cbase_reg, cbase_next, ccur_reg, ccur_next;
    logic [15:0] tbase_reg, tbase_next, tcur_reg, tcur_next;
    logic [4:0] ctl_reg, ctl_next;
    logic [2:0] stat_reg, stat_next, mask_reg, mask_next;
    logic [31:0] div_reg, div_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next, bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_fire, tick, pbeat_sync1, pbeat_sync2, cbeat_sync1, cbeat_sync2;
    logic [5:0] widx, ridx;
    logic [15:0] wval;
    logic [2:0] ev;
    logic [31:0] rd_val;
    logic rd_hit, wr_hit;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign wr_fire = aw_have_reg && w_have_reg;
    assign widx = awaddr_reg[7:2];
    assign ridx = s_axi_araddr[7:2];

    assign play_rate_hz = prate_reg;
    assign rec_rate_hz = ctl_reg[CTL_INDEP_RATE] ? crate_reg : prate_reg;
    // Attenuation codes and mute bits go straight to the mixer; 1.5 dB per code step, mute bit wins.
    assign voice_atten = att_reg[0];
    assign synth_atten = att_reg[1];
    assign serial1_atten = att_reg[2];
    assign serial0_atten = att_reg[3];
    assign play_channel_enable = ctl_reg[CTL_PLAY_EN];
    assign rec_channel_enable = ctl_reg[CTL_REC_EN];
    assign irq = |(stat_reg & mask_reg);

    // Low 16 bits of the held write data, taken whole with no strobe merge; the upper lanes hold nothing.
    always_comb begin
        wval = 16'h0000;
        wval[7:0] = wdata_reg[7:0];
        wval[15:8] = wdata_reg[15:8];
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (ridx)
            IDX_PLAY_RATE: rd_val[15:0] = prate_reg;
            IDX_REC_RATE: rd_val[15:0] = crate_reg;
            IDX_VOICE_ATT: rd_val[15:0] = att_reg[0];
            IDX_SYNTH_ATT: rd_val[15:0] = att_reg[1];
            IDX_SER1_ATT: rd_val[15:0] = att_reg[2];
            IDX_SER0_ATT: rd_val[15:0] = att_reg[3];
            IDX_PLAY_BASE: rd_val[15:0] = pbase_reg;
            IDX_PLAY_CUR: rd_val[15:0] = pcur_reg;
            IDX_REC_BASE: rd_val[15:0] = cbase_reg;
            IDX_REC_CUR: rd_val[15:0] = ccur_reg;
            IDX_TICK_BASE: rd_val[15:0] = tbase_reg;
            IDX_TICK_CUR: rd_val[15:0] = tcur_reg;
            IDX_CONTROL: rd_val[4:0] = ctl_reg;
            IDX_EFF_REC_RATE: rd_val[15:0] = rec_rate_hz;
            IDX_IRQ_STATUS: rd_val[2:0] = stat_reg;
            IDX_IRQ_MASK: rd_val[2:0] = mask_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    // Timebase divider: one enable pulse per selected period, restarted while the timer is off.
    always_comb begin
        tick = 1'b0;
        div_next = div_reg + 32'd1;
        if (!ctl_reg[CTL_TICK_EN]) begin
            div_next = 32'd0;
        end else if (div_reg >= (ctl_reg[CTL_TICK_SEL] ? 32'(LONG_CYCLES - 1) : 32'(SHORT_CYCLES - 1))) begin
            div_next = 32'd0;
            tick = 1'b1;
        end
    end

    always_comb begin
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        prate_next = prate_reg;
        crate_next = crate_reg;
        att_next = att_reg;
        pbase_next = pbase_reg;
        pcur_next = pcur_reg;
        cbase_next = cbase_reg;
        ccur_next = ccur_reg;
        tbase_next = tbase_reg;
        tcur_next = tcur_reg;
        ctl_next = ctl_reg;
        mask_next = mask_reg;
        ev = 3'b000;
        wr_hit = 1'b1;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_next = s_axi_awaddr;
            aw_have_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
            w_have_next = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next = rd_val;
            rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        // Counters run first so that a register write in the same cycle takes precedence.
        if (ctl_reg[CTL_PLAY_EN] && pbeat_sync2) begin
            pcur_next = (pcur_reg == 16'h0000) ? pbase_reg : pcur_reg - 16'h0001;
            ev[IRQ_PLAY] = (pcur_reg == 16'h0000);
        end
        if (ctl_reg[CTL_REC_EN] && cbeat_sync2) begin
            ccur_next = (ccur_reg == 16'h0000) ? cbase_reg : ccur_reg - 16'h0001;
            ev[IRQ_REC] = (ccur_reg == 16'h0000);
        end
        if (tick) begin
            tcur_next = (tcur_reg == 16'h0000) ? tbase_reg : tcur_reg - 16'h0001;
            ev[IRQ_TICK] = (tcur_reg == 16'h0000);
        end
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            if (wstrb_reg[1:0] == 2'b11) begin
                // Sixteen-bit registers update only on a full low half-word; partial writes are dropped.
                unique case (widx)
                    IDX_PLAY_RATE: prate_next = wval;
                    IDX_REC_RATE: crate_next = wval;
                    IDX_VOICE_ATT: att_next[0] = wval & 16'hbfbf;
                    IDX_SYNTH_ATT: att_next[1] = wval & 16'hbfbf;
                    IDX_SER1_ATT: att_next[2] = wval & 16'hbfbf;
                    IDX_SER0_ATT: att_next[3] = wval & 16'hbfbf;
                    IDX_PLAY_BASE: begin
                        pbase_next = wval;
                        pcur_next = wval;
                    end
                    IDX_PLAY_CUR: pcur_next = wval;
                    IDX_REC_BASE: begin
                        cbase_next = wval;
                        ccur_next = wval;
                    end
                    IDX_REC_CUR: ccur_next = wval;
                    IDX_TICK_BASE: begin
                        tbase_next = wval;
                        tcur_next = wval;
                    end
                    IDX_TICK_CUR: tcur_next = wval;
                    IDX_CONTROL: ctl_next = wval[4:0];
                    IDX_EFF_REC_RATE: ;
                    IDX_IRQ_STATUS: ;
                    IDX_IRQ_MASK: mask_next = wval[2:0];
                    default: wr_hit = 1'b0;
                endcase
            end
            bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_comb begin
        stat_next = stat_reg | ev;
        if (wr_fire && widx == IDX_IRQ_STATUS && wstrb_reg[0]) begin
            stat_next = (stat_reg & ~wdata_reg[2:0]) | ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pbeat_sync1 <= 1'b0;
            pbeat_sync2 <= 1'b0;
            cbeat_sync1 <= 1'b0;
            cbeat_sync2 <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
            prate_reg <= RATE_RESET;
            crate_reg <= RATE_RESET;
            for (int i = 0; i < 4; i++) begin
                att_reg[i] <= ATT_RESET;
            end
            pbase_reg <= COUNT_RESET;
            pcur_reg <= COUNT_RESET;
            cbase_reg <= COUNT_RESET;
            ccur_reg <= COUNT_RESET;
            tbase_reg <= COUNT_RESET;
            tcur_reg <= COUNT_RESET;
            ctl_reg <= 5'h00;
            stat_reg <= 3'h0;
            mask_reg <= 3'h0;
            div_reg <= 32'd0;
        end else begin
            pbeat_sync1 <= play_dma_beat;
            pbeat_sync2 <= pbeat_sync1;
            cbeat_sync1 <= rec_dma_beat;
            cbeat_sync2 <= cbeat_sync1;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            prate_reg <= prate_next;
            crate_reg <= crate_next;
            att_reg <= att_next;
            pbase_reg <= pbase_next;
            pcur_reg <= pcur_next;
            cbase_reg <= cbase_next;
            ccur_reg <= ccur_next;
            tbase_reg <= tbase_next;
            tcur_reg <= tcur_next;
            ctl_reg <= ctl_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            div_reg <= div_next;
        end
    end
endmodule // audio_rate_gain_count_regs

/* test/audio_regs_monitor.sv */
// Concurrent checks on the ports of the audio register bank.
`timescale 1ns/10ps
module audio_regs_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] play_rate_hz,
    input wire logic [15:0] rec_rate_hz,
    input wire logic [15:0] voice_atten,
    input wire logic play_channel_enable,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // The held address and data meet one cycle after both are taken, so the answer shows two edges later.
    write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    // Reset itself is checked here, so this one is not disabled by it.
    reset_values_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !irq &&
        play_rate_hz == 16'h1f40 && rec_rate_hz == 16'h1f40 && voice_atten == 16'h8080) else $error("bad reset value");
    write_only_a: assert property ($changed(play_rate_hz) || $changed(play_channel_enable) |-> $rose(s_axi_bvalid))
        else $error("register changed without a write");
    atten_reserved_a: assert property (!voice_atten[14] && !voice_atten[6]) else $error("reserved bit set");
endmodule // audio_regs_monitor

/* test/audio_rate_gain_count_regs_tb_top.sv */
// Self-checking testbench for the audio register bank.
`timescale 1ns/10ps
module audio_rate_gain_count_regs_tb_top;
    import audio_regs_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic play_dma_beat = 1'b0, rec_dma_beat = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic play_channel_enable, rec_channel_enable;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd_val, last_resp;
    logic [15:0] play_rate_hz, rec_rate_hz, voice_atten, synth_atten, serial1_atten, serial0_atten;
    logic [5:0] i;
    int mismatches = 0, checks_done = 0, n_irq;
    // Short timer periods keep the run brief; expectations below use 20 and 5.
    audio_rate_gain_count_regs #(.LONG_CYCLES(20), .SHORT_CYCLES(5)) u_audio_rate_gain_count_regs (.*);
    initial forever #10 aclk = ~aclk;
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [5:0] idx, input logic [15:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        last_resp = {30'h0, s_axi_bresp};
        if (n >= 50) begin
            mismatches++;
            end_sim;
        end
    endtask
    task rd(input logic [5:0] idx);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        rd_val = s_axi_rdata;
        last_resp = {30'h0, s_axi_rresp};
        if (n >= 50) begin
            mismatches++;
            end_sim;
        end
    endtask
    task rd_chk(input logic [5:0] idx, input logic [31:0] exp);
        rd(idx);
        check(rd_val, exp);
    endtask
    // One beat is a single high cycle; the wait covers the two-stage input synchroniser.
    task beat(input bit rec);
        @(posedge aclk);
        if (rec) rec_dma_beat <= 1'b1;
        else play_dma_beat <= 1'b1;
        @(posedge aclk);
        play_dma_beat <= 1'b0;
        rec_dma_beat <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
    task wait_irq;
        n_irq = 0;
        while (irq !== 1'b1 && n_irq < 60) begin
            @(posedge aclk);
            n_irq++;
        end
        if (n_irq >= 60) begin
            mismatches++;
            end_sim;
        end
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 6'h02; i < 6'h0e; i++) rd_chk(i, i < 4 ? 32'h1f40 : i < 8 ? 32'h8080 : 32'h0);
        wr(IDX_PLAY_RATE, 16'hd7a0);
        wr(IDX_REC_RATE, 16'h0fa0);
        check({16'h0, rec_rate_hz}, 32'hd7a0);
        rd_chk(IDX_EFF_REC_RATE, 32'hd7a0);
        wr(IDX_CONTROL, 16'h0010);
        check({16'h0, rec_rate_hz}, 32'h0fa0);
        wr(IDX_PLAY_RATE, 16'h0fa0);
        check({16'h0, play_rate_hz}, 32'h0fa0);
        // A write with a lane of the low half-word disabled must leave the register alone.
        s_axi_wstrb <= 4'h1;
        wr(IDX_PLAY_RATE, 16'h1f40);
        s_axi_wstrb <= 4'hf;
        check(last_resp, {30'h0, RESP_OKAY});
        rd_chk(IDX_PLAY_RATE, 32'h0fa0);
        for (i = 6'h04; i < 6'h08; i++) begin
            wr(i, 16'hffff);
            rd_chk(i, 32'hbfbf);
            wr(i, 16'h013f);
            rd_chk(i, 32'h013f);
        end
        check({16'h0, voice_atten}, 32'h013f);
        check({16'h0, synth_atten}, 32'h013f);
        check({16'h0, serial1_atten}, 32'h013f);
        check({16'h0, serial0_atten}, 32'h013f);
        wr(IDX_VOICE_ATT, 16'h8000);
        check({16'h0, voice_atten}, 32'h8000);
        rd_chk(6'h01, 32'h0);
        check(last_resp, {30'h0, RESP_SLVERR});
        wr(IDX_IRQ_MASK, 16'h0005);
        wr(IDX_PLAY_BASE, 16'h0002);
        rd_chk(IDX_PLAY_CUR, 32'h2);
        wr(IDX_REC_BASE, 16'h0000);
        wr(IDX_CONTROL, 16'h0003);
        check({30'h0, play_channel_enable, rec_channel_enable}, 32'h3);
        beat(0);
        rd_chk(IDX_PLAY_CUR, 32'h1);
        beat(0);
        rd_chk(IDX_PLAY_CUR, 32'h0);
        check({31'h0, irq}, 32'h0);
        beat(0);
        rd_chk(IDX_PLAY_CUR, 32'h2);
        check({31'h0, irq}, 32'h1);
        beat(1);
        rd_chk(IDX_REC_CUR, 32'h0);
        rd_chk(IDX_IRQ_STATUS, 32'h3);
        wr(IDX_IRQ_STATUS, 16'h0001);
        check({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_STATUS, 16'h0002);
        wr(IDX_TICK_BASE, 16'h0000);
        wr(IDX_CONTROL, 16'h000c);
        wait_irq;
        check({31'h0, n_irq >= 16 && n_irq <= 22}, 32'h1);
        wr(IDX_CONTROL, 16'h0000);
        wr(IDX_IRQ_STATUS, 16'h0004);
        wr(IDX_TICK_BASE, 16'h0001);
        rd_chk(IDX_TICK_CUR, 32'h1);
        wr(IDX_CONTROL, 16'h0004);
        wait_irq;
        check({31'h0, n_irq >= 7 && n_irq <= 12}, 32'h1);
        end_sim;
    end
endmodule // audio_rate_gain_count_regs_tb_top
bind audio_rate_gain_count_regs audio_regs_monitor u_audio_regs_monitor (.*);
